// [common/ppc_pkg.sv]
// Purpose: Shared constants for the port pin configuration block
// Assumes: APB byte address is four times the register index
// Notes: Index values stay as printed; byte addresses derive from them
package ppc_pkg;
   localparam int PPC_NPINS = 3;
   localparam int PPC_AW = 8;
   localparam int PPC_CFG_W = 4;
   // Register indices
   localparam logic [7:0] PPC_IDX_P0_PIN3 = 8'h13;
   localparam logic [7:0] PPC_IDX_P1_PIN1 = 8'h15;
   localparam logic [7:0] PPC_IDX_P1_PIN2 = 8'h16;
   localparam logic [7:0] PPC_IDX_PULL_CTRL = 8'h1D;
   localparam logic [7:0] PPC_IDX_PIN_STATUS = 8'h1C;
   localparam logic [7:0] PPC_IDX_CFG [PPC_NPINS] = '{
      PPC_IDX_P0_PIN3, PPC_IDX_P1_PIN1, PPC_IDX_P1_PIN2};
   // Field positions inside a pin configuration word and the pull control word
   localparam int PPC_BIT_IRQ_EN = 3;
   localparam int PPC_BIT_SAMPLE_SEL = 2;
   localparam int PPC_BIT_DIR = 1;
   localparam int PPC_BIT_MODE = 0;
   localparam int PPC_BIT_PULL_POL = 0;
   // Reset values
   localparam logic [3:0] PPC_CFG_RST = 4'h0;
   localparam logic PPC_PULL_POL_RST = 1'b0;
   // Sampling clock timing
   localparam int PPC_CLK_HZ = 50_000_000;
   localparam int PPC_SAMPLE_HZ = 64;
   localparam int PPC_TICK_CYCLES = PPC_CLK_HZ / PPC_SAMPLE_HZ;
   localparam int PPC_DIV_W = 20;
endpackage

// [logic/ppc_pin_cell.sv]
// Purpose: Pad control and change detection for one configured port pin
// Assumes: Pin level and port data are synchronous to the clock
// Notes: All outputs are registered
`timescale 1ns/1ps
module ppc_pin_cell
   import ppc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [PPC_CFG_W-1:0] cfg,
   input wire logic tick64,
   input wire logic pin_in,
   input wire logic port_data,
   output logic pin_out,
   output logic pin_oe_n,
   output logic pull_en,
   output logic irq,
   output logic level
);
   logic pin_out_ff;
   logic oe_n_ff;
   logic pull_ff;
   logic irq_ff;
   logic sample_ff;
   logic strobe;
   logic nxt_out;
   logic nxt_oe_n;

   assign pin_out = pin_out_ff;
   assign pin_oe_n = oe_n_ff;
   assign pull_en = pull_ff;
   assign irq = irq_ff;
   assign level = sample_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Pad control
   always_comb begin
      nxt_out = 1'b0;
      nxt_oe_n = 1'b1;
      if (cfg[PPC_BIT_DIR]) begin // R5
         if (cfg[PPC_BIT_MODE]) begin // R7
            nxt_out = 1'b0;
            nxt_oe_n = port_data;
         end else begin
            nxt_out = port_data;
            nxt_oe_n = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_out_ff <= 1'b0;
         oe_n_ff <= 1'b1;
         pull_ff <= 1'b1;
      end else if (ce) begin
         pin_out_ff <= nxt_out;
         oe_n_ff <= nxt_oe_n;
         pull_ff <= !cfg[PPC_BIT_DIR] && !cfg[PPC_BIT_MODE]; // R6
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Change detection on the selected sampling clock
   assign strobe = cfg[PPC_BIT_SAMPLE_SEL] ? 1'b1 : tick64; // R4

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sample_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else if (ce) begin
         if (strobe) begin
            sample_ff <= pin_in;
         end
         irq_ff <= strobe && cfg[PPC_BIT_IRQ_EN] && (pin_in != sample_ff); // R3 R10
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   irq_gate_a: assert property (irq |-> $past(cfg[PPC_BIT_IRQ_EN])) // R3
      else $error("pin interrupt raised while disabled");
   slow_sample_a: assert property ( // R4
      ce && !cfg[PPC_BIT_SAMPLE_SEL] && !tick64 |=> $stable(sample_ff))
      else $error("pin sampled without the slow tick");
   input_hiz_a: assert property (ce && !cfg[PPC_BIT_DIR] |=> pin_oe_n) // R5
      else $error("input pin is driven");
   pull_select_a: assert property ( // R6
      ce && !cfg[PPC_BIT_DIR] |=> pull_en == !$past(cfg[PPC_BIT_MODE]))
      else $error("termination does not follow mode bit");
   open_drain_a: assert property ( // R7
      ce && cfg[PPC_BIT_DIR] && cfg[PPC_BIT_MODE] |=> !pin_out && pin_oe_n == $past(port_data))
      else $error("open drain drives high");
   change_irq_a: assert property ( // R10
      ce && cfg[PPC_BIT_IRQ_EN] && cfg[PPC_BIT_SAMPLE_SEL] && pin_in != sample_ff |=> irq)
      else $error("pin change missed");
   irq_cov: cover property (irq);
   od_cov: cover property (cfg[PPC_BIT_DIR] && cfg[PPC_BIT_MODE] && !pin_oe_n);
endmodule

// [logic/ppc_port_pins.sv]
// Purpose: APB register file and pad control for three port pins
// Assumes: APB3 master; zero wait states while CE is high, as PREADY follows CE
// Notes: Configuration registers are write only and read as zero
// Function
// R1 - Each pin has one 4-bit configuration register in register space
// R2 - Software writes whole words only; reads return no configuration
// R3 - Bit 3 enables the pin's external interrupt, cleared at reset
// R4 - Bit 2 picks sampling clock: 0 is 64 Hz, 1 system clock
// R5 - Bit 1 sets direction: 0 input, 1 output from port data
// R6 - As input, bit 0 picks resistor termination (0) or high impedance (1)
// R7 - As output, bit 0 picks push-pull (0) or open drain (1)
// R8 - Every port 1 pin is configured on its own
// R9 - One shared bit picks pull-up or pull-down, cleared at reset
// R10 - Enabled interrupt fires on a change between consecutive samples
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module ppc_port_pins
   import ppc_pkg::*;
#(
   parameter int TICK_DIV = ppc_pkg::PPC_TICK_CYCLES
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ppc_pkg::PPC_AW-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [ppc_pkg::PPC_NPINS-1:0] PIN_IN,
   input wire logic [ppc_pkg::PPC_NPINS-1:0] PORT_DATA,
   output logic [ppc_pkg::PPC_NPINS-1:0] PIN_OUT,
   output logic [ppc_pkg::PPC_NPINS-1:0] PIN_OE_N,
   output logic [ppc_pkg::PPC_NPINS-1:0] PULL_EN,
   output logic [ppc_pkg::PPC_NPINS-1:0] PULL_UP,
   output logic [ppc_pkg::PPC_NPINS-1:0] EXT_IRQ
);
   import ppc_pkg::*;

   logic [PPC_CFG_W-1:0] cfg_ff [PPC_NPINS];
   logic pull_pol_ff;
   logic [31:0] prdata_ff;
   logic pslverr_ff;
   logic [PPC_DIV_W-1:0] div_ff;
   logic tick64;
   logic [PPC_NPINS-1:0] level;
   logic setup;
   logic wr_access;
   logic [PPC_NPINS-1:0] hit_cfg;
   logic hit_pull;
   logic hit_stat;
   logic [31:0] nxt_rdata;
   logic [PPC_DIV_W-1:0] gap_ff;

   localparam logic [PPC_DIV_W-1:0] DIV_LAST = PPC_DIV_W'(TICK_DIV - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   assign setup = PSEL && !PENABLE;
   assign wr_access = PSEL && PENABLE && PWRITE;
   assign hit_pull = PADDR == {PPC_IDX_PULL_CTRL[5:0], 2'b00};
   assign hit_stat = PADDR == {PPC_IDX_PIN_STATUS[5:0], 2'b00};

   genvar gi;
   generate
      for (gi = 0; gi < PPC_NPINS; gi++) begin : g_pin
         assign hit_cfg[gi] = PADDR == {PPC_IDX_CFG[gi][5:0], 2'b00};

         // One word per pin, written whole
         always_ff @(posedge MCLK) begin
            if (!RST_N) begin
               cfg_ff[gi] <= PPC_CFG_RST;
            end else if (CE && wr_access && hit_cfg[gi]) begin
               cfg_ff[gi] <= PWDATA[PPC_CFG_W-1:0]; // R1 R8
            end
         end

         ppc_pin_cell u_cell (
            .clk(MCLK),
            .rst_n(RST_N),
            .ce(CE),
            .cfg(cfg_ff[gi]),
            .tick64(tick64),
            .pin_in(PIN_IN[gi]),
            .port_data(PORT_DATA[gi]),
            .pin_out(PIN_OUT[gi]),
            .pin_oe_n(PIN_OE_N[gi]),
            .pull_en(PULL_EN[gi]),
            .irq(EXT_IRQ[gi]),
            .level(level[gi])
         );

         assign PULL_UP[gi] = pull_pol_ff; // R9
      end
   endgenerate

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         pull_pol_ff <= PPC_PULL_POL_RST;
      end else if (CE && wr_access && hit_pull) begin
         pull_pol_ff <= PWDATA[PPC_BIT_PULL_POL]; // R9
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path, registered in the setup cycle
   always_comb begin
      nxt_rdata = 32'h0000_0000; // R2
      if (hit_stat) begin
         nxt_rdata[PPC_NPINS-1:0] = level;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (CE && setup) begin
         prdata_ff <= PWRITE ? 32'h0000_0000 : nxt_rdata;
         pslverr_ff <= !(|hit_cfg || hit_pull || (hit_stat && !PWRITE));
      end
   end

   assign PRDATA = prdata_ff;
   assign PSLVERR = pslverr_ff && PSEL && PENABLE;
   assign PREADY = CE;

   ////////////////////////////////////////////////////////////////////////////
   // Slow sampling tick from the system clock
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         div_ff <= '0;
      end else if (CE) begin
         div_ff <= (div_ff == DIV_LAST) ? '0 : div_ff + 1'b1; // R4
      end
   end

   assign tick64 = div_ff == DIV_LAST;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   cfg_write_a: assert property ( // R1
      CE && wr_access && hit_cfg[0] |=> cfg_ff[0] == $past(PWDATA[3:0]))
      else $error("pin configuration write lost");
   pin_isolate_a: assert property ( // R8
      CE && wr_access && hit_cfg[1] |=> $stable(cfg_ff[2]) && $stable(cfg_ff[0]))
      else $error("write disturbed another pin");
   cfg_read_zero_a: assert property ( // R2
      setup && !PWRITE && |hit_cfg && CE |=> PRDATA == 32'h0000_0000)
      else $error("configuration register readable");
   pull_shared_a: assert property ( // R9
      CE && wr_access && hit_pull |=> PULL_UP == {PPC_NPINS{$past(PWDATA[0])}})
      else $error("shared pull polarity not applied");
   tick_spacing_a: assert property (CE && tick64 |=> !tick64) // R4
      else $error("slow tick too frequent");

   // Cycles since the last slow tick, counted apart from the divider
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         gap_ff <= '0;
      end else if (CE) begin
         gap_ff <= tick64 ? '0 : gap_ff + 1'b1;
      end
   end

   tick_period_a: assert property (CE && tick64 |-> gap_ff == DIV_LAST) // R4
      else $error("slow tick period wrong");
   status_read_a: assert property ( // R10
      CE && setup && !PWRITE && hit_stat |=> PRDATA[PPC_NPINS-1:0] == $past(level))
      else $error("status read does not show samples");
   pull_read_zero_a: assert property ( // R2
      CE && setup && !PWRITE && hit_pull |=> PRDATA == 32'h0000_0000)
      else $error("pull control readable");
   pull_hold_a: assert property ( // R9
      !(CE && wr_access && hit_pull) |=> $stable(PULL_UP))
      else $error("pull polarity changed without a write");
   unmapped_err_a: assert property ( // R1
      CE && setup && !(|hit_cfg) && !hit_pull && !hit_stat ##1 PSEL && PENABLE |-> PSLVERR)
      else $error("unmapped access not refused");

   ////////////////////////////////////////////////////////////////////////////
   // Per pin checks on the top level ports
   generate
      for (gi = 0; gi < PPC_NPINS; gi++) begin : g_chk
         push_pull_a: assert property ( // R7
            @(posedge MCLK) disable iff (!RST_N)
            CE && cfg_ff[gi][PPC_BIT_DIR] && !cfg_ff[gi][PPC_BIT_MODE]
            |=> PIN_OUT[gi] == $past(PORT_DATA[gi]) && !PIN_OE_N[gi])
            else $error("push pull pin not driven from port data");
         input_undriven_a: assert property ( // R5
            @(posedge MCLK) disable iff (!RST_N)
            CE && !cfg_ff[gi][PPC_BIT_DIR] |=> PIN_OE_N[gi])
            else $error("input pin driven");
         pull_term_a: assert property ( // R6
            @(posedge MCLK) disable iff (!RST_N)
            CE && !cfg_ff[gi][PPC_BIT_DIR] |=> PULL_EN[gi] == !$past(cfg_ff[gi][PPC_BIT_MODE]))
            else $error("input termination wrong");
         irq_off_a: assert property ( // R3
            @(posedge MCLK) disable iff (!RST_N)
            CE && !cfg_ff[gi][PPC_BIT_IRQ_EN] |=> !EXT_IRQ[gi])
            else $error("disabled pin raised a request");
         fast_sample_a: assert property ( // R4
            @(posedge MCLK) disable iff (!RST_N)
            CE && cfg_ff[gi][PPC_BIT_SAMPLE_SEL] |=> level[gi] == $past(PIN_IN[gi]))
            else $error("system clock sampling missed a cycle");
         slow_change_a: assert property ( // R10
            @(posedge MCLK) disable iff (!RST_N)
            CE && tick64 && cfg_ff[gi][PPC_BIT_IRQ_EN] && PIN_IN[gi] != level[gi]
            |=> EXT_IRQ[gi])
            else $error("change on slow tick missed");
         quiet_pin_a: assert property ( // R10
            @(posedge MCLK) disable iff (!RST_N)
            CE && PIN_IN[gi] == level[gi] |=> !EXT_IRQ[gi])
            else $error("request without a pin change");
         ce_freeze_a: assert property ( // R8
            @(posedge MCLK) disable iff (!RST_N)
            !CE |=> $stable(cfg_ff[gi]) && $stable(PIN_OE_N[gi]) && $stable(EXT_IRQ[gi]))
            else $error("state moved while clock enable low");
      end
   endgenerate

   wr_cov: cover property (wr_access && hit_cfg[2] ##2 PIN_OE_N[2] == 1'b0);
   rd_cov: cover property (setup && !PWRITE && hit_stat);
   err_cov: cover property (PSLVERR);
endmodule

// [tb/port_pin_control_regs_bench.sv]
// Purpose: Self-checking bench for the port pin configuration block
// Assumes: Zero wait APB slave, sample tick shortened to 8 cycles
// Notes: Pin levels come from the external circuit model
`timescale 1ns/1ps
module port_pin_control_regs_bench;
   import ppc_pkg::*;
   logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ce = 1;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er;
   logic [2:0] pin_in, port_data = '0, pin_out, pin_oe_n, pull_en, pull_up, ext_irq;
   logic [2:0] ext_en = '0, ext_val = '0;
   int n_errors = 0, compares = 0, k;
   ppc_port_pins #(.TICK_DIV(8)) uut (.MCLK(mclk), .RST_N(rst_n), .CE(ce),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in),
      .PORT_DATA(port_data), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
      .PULL_EN(pull_en), .PULL_UP(pull_up), .EXT_IRQ(ext_irq));
   ppc_pin_world far (.clk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pull_en(pull_en), .pull_up(pull_up), .ext_en(ext_en), .ext_val(ext_val),
      .level(pin_in));
   initial begin
      forever #10 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask
   task automatic settle();
      repeat (2) @(posedge mclk);
   endtask
   // Number of cycles a pin's request is high over a window
   task automatic irq_count(input int p, input int cyc, input logic [31:0] exp);
      k = 0;
      repeat (cyc) begin
         @(posedge mclk);
         if (ext_irq[p] === 1'b1) k++;
      end
      chk("irq pulses", k, exp);
   endtask
   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("oe_n", pin_oe_n, 3'b111);
      chk("pull_en", pull_en, 3'b111);
      chk("pull_up", pull_up, 3'b000);
      chk("irq", ext_irq, 3'b000);
   endtask
   task automatic t_regs();
      for (int i = 0; i < PPC_NPINS; i++) begin
         apb(1, {PPC_IDX_CFG[i][5:0], 2'b00}, 32'h0000_0002);
         apb(0, {PPC_IDX_CFG[i][5:0], 2'b00}, 32'h0000_0000);
         chk("cfg read", rd, 32'h0000_0000);
         chk("cfg err", er, 1'b0);
      end
      apb(0, 8'h00, 32'h0000_0000);
      chk("unmapped err", er, 1'b1);
   endtask
   task automatic t_outputs();
      port_data <= 3'b101;
      settle();
      chk("push pull out", pin_out, 3'b101);
      chk("push pull oe", pin_oe_n, 3'b000);
      ce <= 0;
      port_data <= 3'b010;
      settle();
      chk("frozen out", pin_out, 3'b101);
      chk("ready held", pready, 1'b0);
      ce <= 1;
      settle();
      chk("released out", pin_out, 3'b010);
      port_data <= 3'b101;
      apb(1, 8'h4C, 32'h0000_0003);
      settle();
      chk("open drain out", pin_out[0], 1'b0);
      chk("open drain oe", pin_oe_n[0], 1'b1);
      chk("other pin kept", pin_oe_n[2:1], 2'b00);
   endtask
   task automatic t_inputs();
      apb(1, 8'h4C, 32'h0000_0001);
      apb(1, 8'h54, 32'h0000_0000);
      apb(1, 8'h74, 32'h0000_0001);
      settle();
      chk("hi z", {pin_oe_n[0], pull_en[0]}, 2'b10);
      chk("pull on", {pin_oe_n[1], pull_en[1]}, 2'b11);
      chk("pull up", pull_up, 3'b111);
   endtask
   task automatic t_irq();
      ext_en <= 3'b110;
      apb(1, 8'h54, 32'h0000_0004);
      apb(1, 8'h58, 32'h0000_0000);
      repeat (12) @(posedge mclk);
      apb(1, 8'h54, 32'h0000_000C);
      apb(1, 8'h58, 32'h0000_0008);
      ext_val <= 3'b010;
      irq_count(1, 4, 1);
      ext_val <= 3'b110;
      irq_count(2, 12, 1);
      apb(0, 8'h70, 32'h0000_0000);
      chk("status", rd[2:1], 2'b11);
      apb(1, 8'h70, 32'h0000_0000);
      chk("status write err", er, 1'b1);
      apb(1, 8'h54, 32'h0000_0004);
      ext_val <= 3'b000;
      irq_count(1, 12, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1;
      @(posedge mclk);
      t_reset();
      t_regs();
      t_outputs();
      t_inputs();
      t_irq();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      stop_test();
   end
endmodule

// [tb/ppc_pin_world.sv]
// Purpose: External circuit model on the three port pins
// Assumes: The bench may drive a pin itself through ext_en
// Notes: A floating pin toggles every cycle so no stale level survives
`timescale 1ns/1ps
module ppc_pin_world
   import ppc_pkg::*;
(
   input wire logic clk,
   input wire logic [ppc_pkg::PPC_NPINS-1:0] pin_out,
   input wire logic [ppc_pkg::PPC_NPINS-1:0] pin_oe_n,
   input wire logic [ppc_pkg::PPC_NPINS-1:0] pull_en,
   input wire logic [ppc_pkg::PPC_NPINS-1:0] pull_up,
   input wire logic [ppc_pkg::PPC_NPINS-1:0] ext_en,
   input wire logic [ppc_pkg::PPC_NPINS-1:0] ext_val,
   output logic [ppc_pkg::PPC_NPINS-1:0] level
);
   logic [PPC_NPINS-1:0] float_ff = '0;
   always_ff @(posedge clk) begin
      float_ff <= ~float_ff;
   end
   always_comb begin
      for (int i = 0; i < PPC_NPINS; i++) begin
         if (!pin_oe_n[i]) level[i] = pin_out[i];
         else if (ext_en[i]) level[i] = ext_val[i];
         else if (pull_en[i]) level[i] = pull_up[i];
         else level[i] = float_ff[i];
      end
   end
endmodule
